// >>> logic/cfrc_pkg.sv
// Shared types and constants of the card file read and update command engine
package cfrc_pkg;

	// ******************************************************
	// Commands, file kinds, results and states
	// ******************************************************
	typedef enum logic [1:0] {
		CFRC_STATUS_CMD = 2'h0,
		CFRC_TRANSPARENT_READ_CMD = 2'h1,
		CFRC_TRANSPARENT_WRITE_CMD = 2'h2,
		CFRC_RECORD_READ_CMD = 2'h3
	} cfrc_cmd_t;

	typedef enum logic [1:0] {
		CFRC_FILE_NONE = 2'h0,
		CFRC_FILE_TRANSPARENT = 2'h1,
		CFRC_FILE_LINEAR = 2'h2,
		CFRC_FILE_CYCLIC = 2'h3
	} cfrc_file_t;

	typedef enum logic [2:0] {
		CFRC_RES_OK = 3'h0,
		CFRC_RES_NO_ACCESS = 3'h1,
		CFRC_RES_BAD_FILE = 3'h2,
		CFRC_RES_OUT_OF_RANGE = 3'h3,
		CFRC_RES_NO_RECORD = 3'h4,
		CFRC_RES_RESERVED_VALUE = 3'h5,
		CFRC_RES_BAD_LENGTH = 3'h6
	} cfrc_result_t;

	typedef enum logic [1:0] {
		CFRC_INFO_SELECT_DATA = 2'h0,
		CFRC_INFO_NAME_OBJECT = 2'h1,
		CFRC_INFO_NO_DATA = 2'h2
	} cfrc_info_t;

	// Gray codes along idle, decide, issue, wait, pause
	typedef enum logic [2:0] {
		CFRC_IDLE = 3'h0,
		CFRC_DECIDE = 3'h1,
		CFRC_ISSUE = 3'h3,
		CFRC_WAIT = 3'h2,
		CFRC_PAUSE = 3'h6,
		CFRC_WRITE = 3'h7,
		CFRC_WSTORE = 3'h5,
		CFRC_DONE = 3'h4
	} cfrc_state_t;

	// ******************************************************
	// Parameter codings
	// ******************************************************
	localparam logic [7:0] CFRC_APP_NONE = 8'h00;
	localparam logic [7:0] CFRC_APP_INIT = 8'h01;
	localparam logic [7:0] CFRC_APP_TERM = 8'h02;
	localparam logic [7:0] CFRC_STAT_SELECT = 8'h00;
	localparam logic [7:0] CFRC_STAT_NAME = 8'h01;
	localparam logic [7:0] CFRC_STAT_NODATA = 8'h0C;
	localparam int CFRC_P1_OFFSET_SEL_BIT = 7;
	localparam logic [2:0] CFRC_P1_SFI_PREFIX = 3'h4;
	localparam logic [4:0] CFRC_SFI_CURRENT = 5'h00;
	localparam logic [4:0] CFRC_SFI_RESERVED = 5'h1F;
	localparam logic [2:0] CFRC_MODE_NEXT = 3'h2;
	localparam logic [2:0] CFRC_MODE_PREV = 3'h3;
	localparam logic [2:0] CFRC_MODE_ABS = 3'h4;
	localparam logic [7:0] CFRC_REC_CURRENT = 8'h00;
	localparam logic [8:0] CFRC_LEN_ZERO_MEANS = 9'h100;

	// ******************************************************
	// Reset values
	// ******************************************************
	localparam logic [7:0] CFRC_RESET_PTR = 8'h00;
	localparam logic [1:0] CFRC_RESET_APP = 2'h0;

endpackage

// >>> logic/cfrc_fifo.sv
// Small valid/ready buffer for the response byte stream
`timescale 1ns/1ns
`default_nettype none
module cfrc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
	logic [CW-1:0] count_reg, count_next;
	logic push, pop;

	// ******************************************************
	// Pointer and count update
	// ******************************************************
	always_comb begin
		push = inValid && (count_reg != CW'(DEPTH));
		pop = (count_reg != '0) && outReady;
		wp_next = wp_reg;
		rp_next = rp_reg;
		count_next = count_reg;
		if (push) begin
			wp_next = (wp_reg == AW'(DEPTH - 1)) ? '0 : AW'(wp_reg + 1'b1);
		end
		if (pop) begin
			rp_next = (rp_reg == AW'(DEPTH - 1)) ? '0 : AW'(rp_reg + 1'b1);
		end
		if (push && !pop) begin
			count_next = CW'(count_reg + 1'b1);
		end else if (pop && !push) begin
			count_next = CW'(count_reg - 1'b1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			wp_reg <= '0;
			rp_reg <= '0;
			count_reg <= '0;
		end else begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			count_reg <= count_next;
		end
	end

	// Storage has no reset; it is only read while count says valid
	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wp_reg] <= inData;
		end
	end

	assign inReady = (count_reg != CW'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData = mem_reg[rp_reg];
endmodule
`default_nettype wire

// >>> logic/cfrc_engine.sv
// Command engine for status, transparent read/write and record read
`timescale 1ns/1ns
`default_nettype none
// What this block does
// [R1] Status first parameter gives application indication
// [R2] Status second parameter picks returned information
// [R3] Status reports selection, takes no data
// [R4] Terminal sets status length empty, 00, maximum
// [R5] Binary read only when read allowed
// [R6] Top bit zero: fifteen-bit offset
// [R7] Prefix 100: short id, second parameter offset
// [R8] Binary read returns exactly expected length
// [R9] Binary update only when update allowed
// [R10] Update shares read addressing, length gives count
// [R11] Record read only when read allowed
// [R12] Failed record read keeps the pointer
// [R13] Current mode reads pointer, pointer kept
// [R14] Absolute mode reads numbered record
// [R15] Next advances pointer; unset reads first
// [R16] Linear next at last: no data
// [R17] Cyclic next at last wraps first
// [R18] Previous steps back; unset reads last
// [R19] Linear previous at first: no data
// [R20] Cyclic previous at first wraps last
// [R21] Upper five bits: current file or id
// [R22] Low three bits select record mode
// [R23] Terminal sends zero record number there
// [R24] New file selection unsets the pointer
module cfrc_engine
	import cfrc_pkg::*;
#(
	parameter int BUF_DEPTH = 2
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic cmdValid,
	output logic cmdReady,
	input wire cfrc_cmd_t cmdKind,
	input wire logic [7:0] cmdP1,
	input wire logic [7:0] cmdP2,
	input wire logic [7:0] cmdLe,
	input wire logic [7:0] cmdLc,
	output logic sfiSelect,
	output logic [4:0] sfiValue,
	input wire cfrc_file_t fileKind,
	input wire logic [15:0] fileSize,
	input wire logic [7:0] recLen,
	input wire logic [7:0] recCount,
	input wire logic readAllowed,
	input wire logic updateAllowed,
	input wire logic fileChanged,
	output logic memRdEn,
	output logic memWrEn,
	output logic [15:0] memAddr,
	output logic [7:0] memWdata,
	input wire logic [7:0] memRdata,
	input wire logic wrValid,
	output logic wrReady,
	input wire logic [7:0] wrData,
	output logic rspValid,
	input wire logic rspReady,
	output logic [7:0] rspData,
	output logic done,
	output cfrc_result_t result,
	output logic [1:0] appIndication,
	output logic infoReq,
	output cfrc_info_t infoSel,
	output logic [7:0] recPointer,
	output logic pointerSet
);
	cfrc_state_t state_reg, state_next;
	cfrc_cmd_t kind_reg, kind_next;
	cfrc_result_t result_reg, result_next;
	cfrc_info_t infoSel_reg, infoSel_next;
	logic [7:0] p1_reg, p1_next, p2_reg, p2_next, le_reg, le_next, lc_reg, lc_next;
	logic [7:0] ptr_reg, ptr_next, newPtr_reg, newPtr_next;
	logic ptrSet_reg, ptrSet_next, commit_reg, commit_next;
	logic [8:0] remain_reg, remain_next;
	logic [15:0] addr_reg, addr_next;
	logic [7:0] wdata_reg, wdata_next;
	logic [1:0] app_reg, app_next;
	logic [4:0] sfiVal_reg, sfiVal_next;
	logic sfiSel_reg, sfiSel_next, infoReq_reg, infoReq_next, done_reg, done_next;
	logic cmdReady_reg, memRdEn_reg, memWrEn_reg, wrReady_reg;
	logic fifoInValid, fifoInReady;
	logic [15:0] binOffset;
	logic [8:0] binLen, recRdLen;
	logic [16:0] binEnd;
	logic binReserved, binBySfi;
	logic [7:0] recSel;
	logic recFail, recReserved;
	cfrc_result_t recRes;
	logic [15:0] recBase;

	// ******************************************************
	// Helpers
	// ******************************************************
	// Zero in the expected length means the full short-form span
	function automatic logic [8:0] cfrc_len(input logic [7:0] raw);
		cfrc_len = (raw == 8'h00) ? CFRC_LEN_ZERO_MEANS : {1'b0, raw};
	endfunction

	function automatic logic cfrc_is_record(input cfrc_file_t k);
		cfrc_is_record = (k == CFRC_FILE_LINEAR) || (k == CFRC_FILE_CYCLIC);
	endfunction

	// ******************************************************
	// Transparent file addressing
	// ******************************************************
	always_comb begin
		binBySfi = (p1_reg[7:5] == CFRC_P1_SFI_PREFIX); // [R7]
		binReserved = p1_reg[CFRC_P1_OFFSET_SEL_BIT] && !binBySfi;
		if (!p1_reg[CFRC_P1_OFFSET_SEL_BIT]) begin
			binOffset = {1'b0, p1_reg[6:0], p2_reg}; // [R6]
		end else begin
			binOffset = {8'h00, p2_reg}; // [R7]
		end
		// Update takes its count from the command length [R10]
		binLen = (kind_reg == CFRC_TRANSPARENT_WRITE_CMD) ? {1'b0, lc_reg} : cfrc_len(le_reg);
		binEnd = {1'b0, binOffset} + {8'h00, binLen};
	end

	// ******************************************************
	// Record selection and pointer movement
	// ******************************************************
	always_comb begin
		recSel = ptr_reg;
		recFail = 1'b0;
		recRes = CFRC_RES_OK;
		recReserved = (p2_reg[7:3] == CFRC_SFI_RESERVED); // [R21]
		case (p2_reg[2:0]) // [R22]
			CFRC_MODE_NEXT: begin
				if (!ptrSet_reg) begin
					recSel = 8'h01; // [R15]
				end else if (ptr_reg == recCount) begin
					if (fileKind == CFRC_FILE_CYCLIC) begin
						recSel = 8'h01; // [R17]
					end else begin
						recFail = 1'b1; // [R16]
					end
				end else begin
					recSel = 8'(ptr_reg + 8'h01); // [R15]
				end
			end
			CFRC_MODE_PREV: begin
				if (!ptrSet_reg) begin
					recSel = recCount; // [R18]
				end else if (ptr_reg == 8'h01) begin
					if (fileKind == CFRC_FILE_CYCLIC) begin
						recSel = recCount; // [R20]
					end else begin
						recFail = 1'b1; // [R19]
					end
				end else begin
					recSel = 8'(ptr_reg - 8'h01); // [R18]
				end
			end
			CFRC_MODE_ABS: begin
				if (p1_reg == CFRC_REC_CURRENT) begin
					recSel = ptr_reg; // [R13]
					recFail = !ptrSet_reg;
				end else begin
					recSel = p1_reg; // [R14]
				end
			end
			default: begin
				recReserved = 1'b1;
			end
		endcase
		if (recFail || recCount == 8'h00) begin
			recRes = CFRC_RES_NO_RECORD;
		end else if (recSel > recCount) begin
			recRes = CFRC_RES_OUT_OF_RANGE;
		end
		recRdLen = (le_reg == 8'h00) ? {1'b0, recLen} : {1'b0, le_reg};
		recBase = 16'((16'(recSel) - 16'h0001) * 16'(recLen));
	end

	// ******************************************************
	// Sequencer
	// ******************************************************
	always_comb begin
		state_next = state_reg;
		kind_next = kind_reg;
		p1_next = p1_reg;
		p2_next = p2_reg;
		le_next = le_reg;
		lc_next = lc_reg;
		result_next = result_reg;
		infoSel_next = infoSel_reg;
		ptr_next = ptr_reg;
		ptrSet_next = ptrSet_reg;
		newPtr_next = newPtr_reg;
		commit_next = commit_reg;
		remain_next = remain_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		app_next = app_reg;
		sfiVal_next = sfiVal_reg;
		sfiSel_next = 1'b0;
		infoReq_next = 1'b0;
		fifoInValid = 1'b0;
		case (state_reg)
			CFRC_IDLE: begin
				if (cmdValid) begin
					kind_next = cmdKind;
					p1_next = cmdP1;
					p2_next = cmdP2;
					le_next = cmdLe;
					lc_next = cmdLc;
					commit_next = 1'b0;
					state_next = CFRC_DECIDE;
					// Short id referencing selects a new file before the decision
					if (cmdKind == CFRC_TRANSPARENT_READ_CMD
						|| cmdKind == CFRC_TRANSPARENT_WRITE_CMD) begin
						if (cmdP1[7:5] == CFRC_P1_SFI_PREFIX) begin
							sfiSel_next = 1'b1; // [R7]
							sfiVal_next = cmdP1[4:0];
						end
					end else if (cmdKind == CFRC_RECORD_READ_CMD) begin
						if (cmdP2[7:3] != CFRC_SFI_CURRENT
							&& cmdP2[7:3] != CFRC_SFI_RESERVED) begin
							sfiSel_next = 1'b1; // [R21]
							sfiVal_next = cmdP2[7:3];
						end
					end
				end
			end
			CFRC_DECIDE: begin
				state_next = CFRC_DONE;
				result_next = CFRC_RES_OK;
				case (kind_reg)
					CFRC_STATUS_CMD: begin
						// Expected length is not checked; any reply size is allowed [R4]
						if (p1_reg != CFRC_APP_NONE && p1_reg != CFRC_APP_INIT
							&& p1_reg != CFRC_APP_TERM) begin
							result_next = CFRC_RES_RESERVED_VALUE;
						end else if (p2_reg == CFRC_STAT_SELECT) begin
							infoSel_next = CFRC_INFO_SELECT_DATA; // [R2]
						end else if (p2_reg == CFRC_STAT_NAME) begin
							infoSel_next = CFRC_INFO_NAME_OBJECT; // [R2]
						end else if (p2_reg == CFRC_STAT_NODATA) begin
							infoSel_next = CFRC_INFO_NO_DATA; // [R2]
						end else begin
							result_next = CFRC_RES_RESERVED_VALUE;
						end
						if (result_next == CFRC_RES_OK) begin
							app_next = p1_reg[1:0]; // [R1]
							infoReq_next = 1'b1; // [R3]
						end
					end
					CFRC_TRANSPARENT_READ_CMD, CFRC_TRANSPARENT_WRITE_CMD: begin
						if (binReserved) begin
							result_next = CFRC_RES_RESERVED_VALUE;
						end else if (fileKind != CFRC_FILE_TRANSPARENT) begin
							result_next = CFRC_RES_BAD_FILE;
						end else if (kind_reg == CFRC_TRANSPARENT_READ_CMD && !readAllowed) begin
							result_next = CFRC_RES_NO_ACCESS; // [R5]
						end else if (kind_reg == CFRC_TRANSPARENT_WRITE_CMD
							&& !updateAllowed) begin
							result_next = CFRC_RES_NO_ACCESS; // [R9]
						end else if (binEnd > {1'b0, fileSize}) begin
							result_next = CFRC_RES_OUT_OF_RANGE;
						end else if (binLen != 9'h000) begin
							addr_next = binOffset;
							remain_next = binLen; // [R8]
							if (kind_reg == CFRC_TRANSPARENT_READ_CMD) begin
								state_next = CFRC_PAUSE;
							end else begin
								state_next = CFRC_WRITE; // [R10]
							end
						end
					end
					default: begin
						if (recReserved) begin
							result_next = CFRC_RES_RESERVED_VALUE;
						end else if (!cfrc_is_record(fileKind)) begin
							result_next = CFRC_RES_BAD_FILE;
						end else if (!readAllowed) begin
							result_next = CFRC_RES_NO_ACCESS; // [R11]
						end else if (recRes != CFRC_RES_OK) begin
							result_next = recRes;
						end else if (recRdLen > {1'b0, recLen} || recRdLen == 9'h000) begin
							result_next = CFRC_RES_BAD_LENGTH;
						end else begin
							addr_next = recBase;
							remain_next = recRdLen;
							newPtr_next = recSel;
							commit_next = (p2_reg[2:0] != CFRC_MODE_ABS); // [R14]
							state_next = CFRC_PAUSE;
						end
					end
				endcase
			end
			CFRC_PAUSE: begin
				// One read in flight at a time, so room now means room at capture
				if (fifoInReady) begin
					state_next = CFRC_ISSUE;
				end
			end
			CFRC_ISSUE: begin
				state_next = CFRC_WAIT;
			end
			CFRC_WAIT: begin
				fifoInValid = 1'b1;
				addr_next = 16'(addr_reg + 16'h0001);
				remain_next = 9'(remain_reg - 9'h001);
				state_next = (remain_reg == 9'h001) ? CFRC_DONE : CFRC_PAUSE;
			end
			CFRC_WRITE: begin
				if (wrValid) begin
					wdata_next = wrData;
					state_next = CFRC_WSTORE;
				end
			end
			CFRC_WSTORE: begin
				addr_next = 16'(addr_reg + 16'h0001); // [R10]
				remain_next = 9'(remain_reg - 9'h001);
				state_next = (remain_reg == 9'h001) ? CFRC_DONE : CFRC_WRITE;
			end
			CFRC_DONE: begin
				// Pointer moves only on a record read that ends with an OK result [R12]
				if (commit_reg && result_reg == CFRC_RES_OK) begin
					ptr_next = newPtr_reg;
					ptrSet_next = 1'b1;
				end
				state_next = CFRC_IDLE;
			end
			default: begin
				state_next = CFRC_IDLE;
			end
		endcase
		// A new selection beats any commit in the same cycle [R24]
		if (sfiSel_next || fileChanged) begin
			ptrSet_next = 1'b0;
			ptr_next = CFRC_RESET_PTR;
		end
		done_next = (state_next == CFRC_DONE);
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg <= CFRC_IDLE;
			kind_reg <= CFRC_STATUS_CMD;
			p1_reg <= 8'h00;
			p2_reg <= 8'h00;
			le_reg <= 8'h00;
			lc_reg <= 8'h00;
			result_reg <= CFRC_RES_OK;
			infoSel_reg <= CFRC_INFO_SELECT_DATA;
			ptr_reg <= CFRC_RESET_PTR;
			ptrSet_reg <= 1'b0;
			newPtr_reg <= CFRC_RESET_PTR;
			commit_reg <= 1'b0;
			remain_reg <= 9'h000;
			addr_reg <= 16'h0000;
			wdata_reg <= 8'h00;
			app_reg <= CFRC_RESET_APP;
			sfiVal_reg <= 5'h00;
			sfiSel_reg <= 1'b0;
			infoReq_reg <= 1'b0;
			done_reg <= 1'b0;
			cmdReady_reg <= 1'b0;
			memRdEn_reg <= 1'b0;
			memWrEn_reg <= 1'b0;
			wrReady_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			kind_reg <= kind_next;
			p1_reg <= p1_next;
			p2_reg <= p2_next;
			le_reg <= le_next;
			lc_reg <= lc_next;
			result_reg <= result_next;
			infoSel_reg <= infoSel_next;
			ptr_reg <= ptr_next;
			ptrSet_reg <= ptrSet_next;
			newPtr_reg <= newPtr_next;
			commit_reg <= commit_next;
			remain_reg <= remain_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			app_reg <= app_next;
			sfiVal_reg <= sfiVal_next;
			sfiSel_reg <= sfiSel_next;
			infoReq_reg <= infoReq_next;
			done_reg <= done_next;
			cmdReady_reg <= (state_next == CFRC_IDLE);
			memRdEn_reg <= (state_next == CFRC_ISSUE);
			memWrEn_reg <= (state_next == CFRC_WSTORE);
			wrReady_reg <= (state_next == CFRC_WRITE);
		end
	end

	// ******************************************************
	// Response buffer
	// ******************************************************
	// Receiver stalls hold the engine in pause, never drop a byte
	cfrc_fifo #(
		.WIDTH(8),
		.DEPTH(BUF_DEPTH)
	) u_rsp_fifo (
		.clk(clk),
		.rstn(rstn),
		.inValid(fifoInValid),
		.inReady(fifoInReady),
		.inData(memRdata),
		.outValid(rspValid),
		.outReady(rspReady),
		.outData(rspData)
	);

	// Outputs straight from flops
	assign cmdReady = cmdReady_reg;
	assign sfiSelect = sfiSel_reg;
	assign sfiValue = sfiVal_reg;
	assign memRdEn = memRdEn_reg;
	assign memWrEn = memWrEn_reg;
	assign memAddr = addr_reg;
	assign memWdata = wdata_reg;
	assign wrReady = wrReady_reg;
	assign done = done_reg;
	assign result = result_reg;
	assign appIndication = app_reg;
	assign infoReq = infoReq_reg;
	assign infoSel = infoSel_reg;
	assign recPointer = ptr_reg;
	assign pointerSet = ptrSet_reg;
endmodule
`default_nettype wire

// >>> dv/cfrc_engine_monitor.sv
// Checker of the command engine decodes, gates and pointer keeping
`timescale 1ns/1ns
`default_nettype none
module cfrc_engine_monitor
	import cfrc_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic cmdValid,
	input wire logic cmdReady,
	input wire cfrc_cmd_t cmdKind,
	input wire logic [7:0] cmdP1,
	input wire logic [7:0] cmdP2,
	input wire logic sfiSelect,
	input wire logic [4:0] sfiValue,
	input wire logic readAllowed,
	input wire logic updateAllowed,
	input wire logic fileChanged,
	input wire logic memRdEn,
	input wire logic memWrEn,
	input wire logic done,
	input wire cfrc_result_t result,
	input wire logic [1:0] appIndication,
	input wire logic infoReq,
	input wire logic [7:0] recPointer
);
	// ********
	// Properties
	// ********
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Command taken this edge
	wire logic take = cmdValid && cmdReady;
	wire logic bin = cmdKind == CFRC_TRANSPARENT_READ_CMD || cmdKind == CFRC_TRANSPARENT_WRITE_CMD;
	status_timing_a: assert property (take && cmdKind == CFRC_STATUS_CMD |-> ##2 done ##1 cmdReady)
		else $error("status answer late");
	app_ind_a: assert property (take && cmdKind == CFRC_STATUS_CMD && cmdP1 <= 8'h02 && cmdP2 == 8'h00
		|-> ##2 done && appIndication == $past(cmdP1[1:0], 2)) else $error("app indication wrong");
	info_ok_a: assert property (infoReq |-> done && result == CFRC_RES_OK)
		else $error("info request without success");
	read_gate_a: assert property (memRdEn |-> readAllowed)
		else $error("read without access");
	write_gate_a: assert property (memWrEn |-> updateAllowed && !memRdEn)
		else $error("write without access");
	ptr_kept_a: assert property (done && result != CFRC_RES_OK && !fileChanged
		|=> recPointer == $past(recPointer)) else $error("pointer moved on failure");
	sfi_decode_a: assert property (take && bin && cmdP1[7:5] == 3'h4
		|=> sfiSelect && sfiValue == $past(cmdP1[4:0])) else $error("short id not decoded");
	offset_mode_a: assert property (take && bin && !cmdP1[7] |=> !sfiSelect)
		else $error("offset mode used short id");
	rec_sfi_a: assert property (take && cmdKind == CFRC_RECORD_READ_CMD
		&& cmdP2[7:3] inside {[1:30]} |=> sfiSelect && sfiValue == $past(cmdP2[7:3]))
		else $error("record short id not decoded");
	mode_rsv_a: assert property (take && cmdKind == CFRC_RECORD_READ_CMD
		&& !(cmdP2[2:0] inside {[2:4]}) |-> ##2 done && result == CFRC_RES_RESERVED_VALUE)
		else $error("reserved mode accepted");
	// Main scenarios seen
	cov_wrap_c: cover property (done && result == CFRC_RES_OK && recPointer == 8'h03);
	cov_write_c: cover property (memWrEn);
	cov_norec_c: cover property (done && result == CFRC_RES_NO_RECORD);
endmodule
`default_nettype wire

// >>> dv/cfrc_mem_model.sv
// File store model answering the engine's byte reads and writes
`timescale 1ns/1ns
`default_nettype none
module cfrc_mem_model (
	input wire logic clk,
	input wire logic memRdEn,
	input wire logic memWrEn,
	input wire logic [15:0] memAddr,
	input wire logic [7:0] memWdata,
	output logic [7:0] memRdata
);
	logic [7:0] store [logic [15:0]];
	// Unwritten bytes read as an address pattern
	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction
	initial memRdata = 8'hC3;
	// Data valid only the cycle after the strobe, scrambled otherwise
	always @(posedge clk) begin
		if (memWrEn)
			store[memAddr] = memWdata;
		if (memRdEn)
			memRdata <= store.exists(memAddr) ? store[memAddr] : pat(memAddr);
		else
			memRdata <= ~memRdata;
	end
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench of the command engine
`timescale 1ns/1ns
`default_nettype none
module tb;
	import cfrc_pkg::*;
	// ********
	// Signals
	// ********
	logic clk = 1'b0, rstn = 1'b0, cmdValid = 1'b0, rspReady = 1'b1, wrValid = 1'b0;
	logic readAllowed = 1'b1, updateAllowed = 1'b1, fileChanged = 1'b0, stall = 1'b0;
	cfrc_cmd_t cmdKind = CFRC_STATUS_CMD;
	cfrc_file_t fileKind = CFRC_FILE_TRANSPARENT;
	logic [7:0] cmdP1 = 8'h00, cmdP2 = 8'h00, cmdLe = 8'h00, cmdLc = 8'h00, wrData = 8'h00;
	logic cmdReady, sfiSelect, memRdEn, memWrEn, wrReady, rspValid, done, infoReq, pointerSet;
	logic [4:0] sfiValue;
	logic [15:0] memAddr;
	logic [7:0] memWdata, memRdata, rspData, recPointer;
	logic [1:0] appIndication;
	cfrc_result_t result, res;
	cfrc_info_t infoSel;
	int errors = 0, num_checks = 0;
	logic [7:0] got[$], wq[$], ex[$];
	logic [7:0] sp2 [3] = '{CFRC_STAT_SELECT, CFRC_STAT_NAME, CFRC_STAT_NODATA};
	cfrc_info_t sinf [3] = '{CFRC_INFO_SELECT_DATA, CFRC_INFO_NAME_OBJECT, CFRC_INFO_NO_DATA};
	logic [7:0] lp2 [9] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h04, 8'h04, 8'h03, 8'h03, 8'h03};
	int lrec [9] = '{1, 2, 3, 0, 3, 1, 2, 1, 0};
	int lptr [9] = '{1, 2, 3, 3, 3, 3, 2, 1, 1};

	cfrc_engine cfrc_engine_inst (.clk(clk), .rstn(rstn), .cmdValid(cmdValid),
		.cmdReady(cmdReady), .cmdKind(cmdKind), .cmdP1(cmdP1), .cmdP2(cmdP2), .cmdLe(cmdLe),
		.cmdLc(cmdLc), .sfiSelect(sfiSelect), .sfiValue(sfiValue), .fileKind(fileKind),
		.fileSize(16'h2000), .recLen(8'h04), .recCount(8'h03), .readAllowed(readAllowed),
		.updateAllowed(updateAllowed), .fileChanged(fileChanged), .memRdEn(memRdEn),
		.memWrEn(memWrEn), .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
		.wrValid(wrValid), .wrReady(wrReady), .wrData(wrData), .rspValid(rspValid),
		.rspReady(rspReady), .rspData(rspData), .done(done), .result(result),
		.appIndication(appIndication), .infoReq(infoReq), .infoSel(infoSel),
		.recPointer(recPointer), .pointerSet(pointerSet));
	cfrc_mem_model cfrc_mem_model_inst (.clk(clk), .memRdEn(memRdEn), .memWrEn(memWrEn),
		.memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata));

	// ********
	// Helpers
	// ********
	always #5 clk = ~clk;
	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic mk(input logic [15:0] b, input int n);
		ex.delete();
		for (int i = 0; i < n; i++)
			ex.push_back(pat(b + 16'(i)));
	endtask
	// Offer one command, feed update bytes, gather reply bytes until done is seen and the reply buffer runs empty
	task automatic cmd(input cfrc_cmd_t k, input logic [7:0] p1, p2, le, lc);
		logic wt, seen;
		got.delete();
		seen = 1'b0;
		@(posedge clk);
		cmdKind <= k;
		cmdP1 <= p1;
		cmdP2 <= p2;
		cmdLe <= le;
		cmdLc <= lc;
		cmdValid <= 1'b1;
		wrValid <= wq.size() != 0;
		if (wq.size() != 0)
			wrData <= wq[0];
		do @(negedge clk); while (cmdReady !== 1'b1);
		@(posedge clk);
		cmdValid <= 1'b0;
		for (int n = 0; n < 400; n++) begin
			@(negedge clk);
			if (seen && rspValid !== 1'b1)
				break;
			if (done === 1'b1) begin
				seen = 1'b1;
				res = result;
			end
			if (rspValid === 1'b1 && rspReady === 1'b1)
				got.push_back(rspData);
			wt = wrValid === 1'b1 && wrReady === 1'b1;
			@(posedge clk);
			rspReady <= stall ? ~rspReady : 1'b1;
			if (wt)
				void'(wq.pop_front());
			wrValid <= wq.size() != 0;
			if (wq.size() != 0)
				wrData <= wq[0];
		end
		chk("done", 1, seen);
	endtask
	task automatic cmp(input cfrc_result_t r);
		chk("result", r, res);
		chk("count", ex.size(), got.size());
		foreach (ex[i])
			chk("byte", ex[i], got[i]);
	endtask
	// Record read with four-byte records, pointer checked after commit
	task automatic rr(input logic [7:0] p1, p2, input int rec, ptr, input cfrc_result_t r);
		mk(16'((rec - 1) * 4), rec != 0 ? 4 : 0);
		cmd(CFRC_RECORD_READ_CMD, p1, p2, 8'h00, 8'h00);
		cmp(r);
		@(negedge clk);
		chk("pointer", 8'(ptr), recPointer);
	endtask
	task automatic pulse_change;
		@(posedge clk);
		fileChanged <= 1'b1;
		@(posedge clk);
		fileChanged <= 1'b0;
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ********
	// Tests
	// ********
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk("pointer reset", 16'h0000, {pointerSet, recPointer});
		for (int i = 0; i < 3; i++) begin
			cmd(CFRC_STATUS_CMD, 8'(i), sp2[i], 8'h00, 8'h00);
			chk("app", 16'(i), appIndication);
			chk("info", sinf[i], infoSel);
		end
		mk(0, 0);
		cmd(CFRC_STATUS_CMD, 8'h00, 8'h05, 8'h00, 8'h00);
		cmp(CFRC_RES_RESERVED_VALUE);
		$display("test status done");
		// Receiver ready only every other cycle throttles the reply buffer
		stall = 1'b1;
		mk(16'h0123, 4);
		cmd(CFRC_TRANSPARENT_READ_CMD, 8'h01, 8'h23, 8'h04, 8'h00);
		cmp(CFRC_RES_OK);
		mk(16'h0010, 2);
		cmd(CFRC_TRANSPARENT_READ_CMD, 8'h85, 8'h10, 8'h02, 8'h00);
		cmp(CFRC_RES_OK);
		stall = 1'b0;
		wq = '{8'hA1, 8'hB2, 8'hC3};
		cmd(CFRC_TRANSPARENT_WRITE_CMD, 8'h00, 8'h40, 8'h00, 8'h03);
		chk("result", CFRC_RES_OK, res);
		wq = '{8'h5E};
		cmd(CFRC_TRANSPARENT_WRITE_CMD, 8'h82, 8'h43, 8'h00, 8'h01);
		chk("result", CFRC_RES_OK, res);
		@(posedge clk);
		updateAllowed <= 1'b0;
		wq = '{8'h11};
		cmd(CFRC_TRANSPARENT_WRITE_CMD, 8'h00, 8'h40, 8'h00, 8'h01);
		chk("result", CFRC_RES_NO_ACCESS, res);
		wq.delete();
		ex = '{8'hA1, 8'hB2, 8'hC3, 8'h5E};
		cmd(CFRC_TRANSPARENT_READ_CMD, 8'h00, 8'h40, 8'h04, 8'h00);
		cmp(CFRC_RES_OK);
		@(posedge clk);
		readAllowed <= 1'b0;
		mk(0, 0);
		cmd(CFRC_TRANSPARENT_READ_CMD, 8'h00, 8'h00, 8'h01, 8'h00);
		cmp(CFRC_RES_NO_ACCESS);
		$display("test transparent done");
		@(posedge clk);
		readAllowed <= 1'b1;
		fileKind <= CFRC_FILE_LINEAR;
		pulse_change();
		// Walk the linear pointer up to the end and back to the start
		for (int i = 0; i < 9; i++)
			rr(8'(i == 5), lp2[i], lrec[i], lptr[i], lrec[i] != 0 ? CFRC_RES_OK : CFRC_RES_NO_RECORD);
		@(posedge clk);
		fileKind <= CFRC_FILE_CYCLIC;
		rr(8'h00, 8'h03, 3, 3, CFRC_RES_OK);
		rr(8'h00, 8'h02, 1, 1, CFRC_RES_OK);
		rr(8'h00, 8'h05, 0, 1, CFRC_RES_RESERVED_VALUE);
		rr(8'h00, 8'hFA, 0, 1, CFRC_RES_RESERVED_VALUE);
		rr(8'h00, 8'h0A, 1, 1, CFRC_RES_OK);
		rr(8'h00, 8'h02, 2, 2, CFRC_RES_OK);
		@(posedge clk);
		readAllowed <= 1'b0;
		rr(8'h00, 8'h02, 0, 2, CFRC_RES_NO_ACCESS);
		@(posedge clk);
		readAllowed <= 1'b1;
		pulse_change();
		rr(8'h00, 8'h03, 3, 3, CFRC_RES_OK);
		$display("test record done");
		test_done();
	end
	// Watchdog well beyond the expected few hundred cycles
	initial begin
		#200000;
		errors++;
		test_done();
	end
endmodule
bind cfrc_engine cfrc_engine_monitor cfrc_engine_monitor_inst (.clk(clk), .rstn(rstn),
	.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdKind(cmdKind), .cmdP1(cmdP1), .cmdP2(cmdP2),
	.sfiSelect(sfiSelect), .sfiValue(sfiValue), .readAllowed(readAllowed),
	.updateAllowed(updateAllowed), .fileChanged(fileChanged), .memRdEn(memRdEn),
	.memWrEn(memWrEn), .done(done), .result(result), .appIndication(appIndication),
	.infoReq(infoReq), .recPointer(recPointer));
`default_nettype wire
